// >>> interrupt_pending_priority_tb.sv
// Register level testbench of the interrupt pending and priority block
`timescale 1ns/100ps
module interrupt_pending_priority_tb;
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, core_int_req, irq;
  logic [6:0] core_vector, seen_vec;
  ipp_pkg::ipp_src_t src = '0;
  int error_cnt = 0, num_checks = 0;
  logic [6:0] vt [25] = '{7'h20, 7'h21, 7'h26, 7'h2a, 7'h03, 7'h09, 7'h0a,
    7'h0e, 7'h0f, 7'h10, 7'h40, 7'h41, 7'h44, 7'h46, 7'h47, 7'h48, 7'h4a,
    7'h4b, 7'h4c, 7'h4d, 7'h4e, 7'h50, 7'h54, 7'h5a, 7'h5e};
  localparam logic [1:0] OK = 2'h0, ERR = 2'h2;

  always #4 aclk = ~aclk;

  ipp_top i_ipp_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .src(src), .core_int_req(core_int_req),
    .core_vector(core_vector), .irq(irq));

  ipp_core_model i_ipp_core_model (.aclk(aclk), .aresetn(aresetn),
    .int_req(core_int_req), .vector(core_vector), .seen_vec(seen_vec));

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Handshakes are judged at the falling edge, where nothing is moving
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    tb = 0;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      if (tb) chk("bresp", 32'(er), 32'(bresp));
      @(posedge aclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
    end
    bready <= 0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    tr = 0;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      if (tr) begin
        chk("rdata", e, rdata);
        chk("rresp", 32'(er), 32'(rresp));
      end
      @(posedge aclk);
      if (ta) arvalid <= 0;
    end
    rready <= 0;
  endtask

  // Source to pending is one edge, pending to vector one more
  task automatic put(input ipp_pkg::ipp_src_t s);
    @(posedge aclk);
    src <= s;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #50000;
    error_cnt++;
    close_out;
  end

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 4; i++) begin
      rc(8'h10 + 8'(4 * i), 32'h0530_9770, OK);
      rc(8'h08 + 8'(4 * i[0]), 32'h0, OK);
      rc(8'h20 + 8'(4 * i[0]), 32'h0, OK);
    end
    wr(8'h14, 32'hffff_ffff, 4'h3, OK);
    rc(8'h14, 32'h0530_fff0, OK);
    wr(8'h14, 32'h0530_9770, 4'hf, OK);
    rc(8'h40, 32'h0, ERR);
    wr(8'h40, 32'h1, 4'hf, ERR);
    put('1);
    rc(8'h08, 32'hc220_20c7, OK);
    rc(8'h0c, 32'hcbbe_8822, OK);
    wr(8'h08, 32'h0, 4'hf, OK);
    wr(8'h0c, 32'hffff_ffff, 4'hf, OK);
    rc(8'h08, 32'hc220_20c7, OK);
    rc(8'h0c, 32'hcbbe_8822, OK);
    chk("int_req", 32'h0, 32'(core_int_req));
    wr(8'h74, 32'h1, 4'hf, OK);
    @(negedge aclk);
    chk("irq", 32'h1, 32'(irq));
    wr(8'h70, 32'h7, 4'hf, OK);
    @(negedge aclk);
    chk("irq", 32'h0, 32'(irq));
    put('0);
    rc(8'h08, 32'h0, OK);
    put('1);
    chk("irq", 32'h1, 32'(irq));
    rc(8'h70, 32'h3, OK);
    wr(8'h74, 32'h0, 4'hf, OK);
    @(negedge aclk);
    chk("irq", 32'h0, 32'(irq));
    wr(8'h20, 32'hffff_ffff, 4'hf, OK);
    wr(8'h24, 32'hffff_ffff, 4'hf, OK);
    rc(8'h20, 32'hc220_20c7, OK);
    for (int i = 0; i < 25; i++) begin
      put(25'h1 << (24 - i));
      chk("vector", 32'(vt[i]), 32'(core_vector));
      chk("int_req", 32'h1, 32'(core_int_req));
      chk("seen", 32'(vt[i]), 32'(seen_vec));
    end
    put(25'h140_0000);
    chk("vector", 32'(vt[0]), 32'(core_vector));
    wr(8'h10, 32'hc0a0_72f0, 4'hf, OK);
    @(negedge aclk);
    chk("vector", 32'(vt[2]), 32'(core_vector));
    rc(8'h04, {vt[2][5:0], 19'h0, vt[2]}, OK);
    wr(8'h20, 32'h0, 4'hf, OK);
    @(negedge aclk);
    chk("int_req", 32'h0, 32'(core_int_req));
    rc(8'h08, 32'h8200_0000, OK);
    wr(8'h20, 32'hffff_ffff, 4'hf, OK);
    put(25'h30_0000);
    chk("vector", 32'(vt[3]), 32'(core_vector));
    put(25'h10_0000);
    chk("vector", 32'(vt[4]), 32'(core_vector));
    close_out;
  end
endmodule

// >>> ipp_core_model.sv
// Core side model that takes the forwarded request and its vector
`timescale 1ns/100ps
module ipp_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic int_req,
  input wire logic [6:0] vector,
  output logic [6:0] seen_vec
);
  // take vector
  // A code is only taken while the request stands, as a real core would
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen_vec <= 7'h00;
    end else begin
      seen_vec <= int_req ? vector : 7'h00;
    end
  end
endmodule

// >>> ipp_fixed_pick.sv
// Fixed-order pick of the lowest numbered active bit of a pending word
`timescale 1ns/100ps
module ipp_fixed_pick (
  input wire logic [31:0] act,
  output logic hit,
  output logic [4:0] idx
);
  always_comb begin
    hit = |act;
    idx = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (act[31 - i]) begin
        idx = 5'(i);
      end
    end
  end
endmodule

// >>> ipp_group_rank.sv
// Picks the lowest numbered programmed position holding an active source
`timescale 1ns/100ps
module ipp_group_rank (
  input wire logic [31:0] prio,
  input wire logic [7:0] src_act,
  output logic hit,
  output logic [2:0] code
);
  logic [7:0] cand;

  genvar p;
  for (p = 0; p < 8; p++) begin : g_pos
    assign cand[p] = src_act[ipp_pkg::fld(prio, p)];
  end

  always_comb begin
    hit = |cand;
    code = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (cand[i]) begin
        code = ipp_pkg::fld(prio, i);
      end
    end
  end
endmodule

// >>> ipp_pkg.sv
// Constants, register map and carrier types of the interrupt pending block
package ipp_pkg;
  localparam logic [7:0] ADDR_VECTOR = 8'h04;
  localparam logic [7:0] ADDR_PEND_UP = 8'h08;
  localparam logic [7:0] ADDR_PEND_LO = 8'h0c;
  localparam logic [7:0] ADDR_PRIO_A = 8'h10;
  localparam logic [7:0] ADDR_PRIO_B = 8'h14;
  localparam logic [7:0] ADDR_PRIO_C = 8'h18;
  localparam logic [7:0] ADDR_PRIO_D = 8'h1c;
  localparam logic [7:0] ADDR_MASK_UP = 8'h20;
  localparam logic [7:0] ADDR_MASK_LO = 8'h24;
  localparam logic [7:0] ADDR_EV_STAT = 8'h70;
  localparam logic [7:0] ADDR_EV_MASK = 8'h74;
  localparam logic [31:0] RST_PRIO = 32'h0530_9770;
  localparam logic [31:0] PRIO_KEEP = 32'hfff0_fff0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Position codes within each group
  localparam logic [2:0] CODE_A_HI = 3'h0;
  localparam logic [2:0] CODE_A_LO = 3'h1;
  localparam logic [2:0] CODE_A_USB = 3'h6;
  localparam logic [2:0] CODE_B_SD = 3'h2;
  localparam logic [2:0] CODE_C_DMA = 3'h2;
  localparam logic [2:0] CODE_D_UART = 3'h0;
  localparam logic [2:0] CODE_D_CAN = 3'h1;
  localparam logic [2:0] CODE_D_I2C1 = 3'h5;
  localparam logic [2:0] CODE_D_I2C2 = 3'h6;
  localparam logic [2:0] CODE_D_SPI = 3'h7;
  localparam logic [7:0] ALLOW_A = 8'h43;
  localparam logic [7:0] ALLOW_B = 8'h04;
  localparam logic [7:0] ALLOW_C = 8'h04;
  localparam logic [7:0] ALLOW_D = 8'he3;
  // Seven-bit vector codes
  localparam logic [6:0] VEC_NONE = 7'h00;
  localparam logic [6:0] VEC_DMA1 = 7'h03;
  localparam logic [6:0] VEC_UART = 7'h09;
  localparam logic [6:0] VEC_CAN = 7'h0a;
  localparam logic [6:0] VEC_I2C1 = 7'h0e;
  localparam logic [6:0] VEC_I2C2 = 7'h0f;
  localparam logic [6:0] VEC_SPI = 7'h10;
  localparam logic [6:0] VEC_HI_COMM = 7'h20;
  localparam logic [6:0] VEC_LO_COMM = 7'h21;
  localparam logic [6:0] VEC_USB = 7'h26;
  localparam logic [6:0] VEC_SD = 7'h2a;
  localparam logic [6:0] VEC_EXT_REQ0 = 7'h30;
  localparam logic [6:0] VEC_SEC = 7'h40;
  localparam logic [6:0] VEC_PIT = 7'h41;
  localparam logic [6:0] VEC_ALARM = 7'h44;
  localparam logic [6:0] VEC_BUS = 7'h46;
  localparam logic [6:0] VEC_DMA2 = 7'h47;
  localparam logic [6:0] VEC_TMR4 = 7'h48;
  localparam logic [6:0] VEC_PORTS = 7'h4a;
  localparam logic [6:0] VEC_GPIO = 7'h4b;
  localparam logic [6:0] VEC_DRAM = 7'h4c;
  localparam logic [6:0] VEC_LBUS = 7'h4d;
  localparam logic [6:0] VEC_TMR2 = 7'h4e;
  localparam logic [6:0] VEC_PMC = 7'h50;
  localparam logic [6:0] VEC_TMR3 = 7'h54;
  localparam logic [6:0] VEC_TMR1 = 7'h5a;
  localparam logic [6:0] VEC_DMA_ERR = 7'h5e;
  localparam logic [6:0] VEC_RESV_LO = 7'h5f;
  // Pending bit numbers, bit 0 being the most significant bit
  localparam int UP_HI = 0, UP_LO = 1, UP_USB = 6, UP_SD = 10, UP_DMA1 = 18;
  localparam int UP_UART = 24, UP_CAN = 25, UP_I2C1 = 29, UP_I2C2 = 30;
  localparam int UP_SPI = 31;
  localparam int LO_SEC = 0, LO_PIT = 1, LO_ALARM = 4, LO_BUS = 6;
  localparam int LO_DMA2 = 7, LO_TMR4 = 8, LO_PORTS = 10, LO_GPIO = 11;
  localparam int LO_DRAM = 12, LO_LBUS = 13, LO_TMR2 = 14, LO_PMC = 16;
  localparam int LO_TMR3 = 20, LO_TMR1 = 26, LO_DMA_ERR = 30;

  typedef struct packed {
    logic hi_comm, lo_comm, usb, sd_host, dma1, uart, can, i2c1, i2c2, spi;
    logic sec_tick, periodic_timer_source, alarm, bus_access, dma2, timer4, ports, gpio;
    logic dram, local_bus, timer2, power_mgmt_source, timer3, timer1, dma_err;
  } ipp_src_t;

  typedef struct packed {
    logic [31:0] prio_a, prio_b, prio_c, prio_d;
    logic [31:0] mask_up, mask_lo, pend_up, pend_lo;
    logic [2:0] ev_stat, ev_mask;
    logic [6:0] vector;
    logic int_req;
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } ipp_state_t;

  localparam ipp_state_t ST_RST = '{prio_a: RST_PRIO, prio_b: RST_PRIO,
    prio_c: RST_PRIO, prio_d: RST_PRIO, default: '0};

  function automatic int hb(input int n);
    return 31 - n;
  endfunction

  function automatic logic [2:0] fld(input logic [31:0] w, input int p);
    return (p < 4) ? w[29 - 3 * p +: 3] : w[13 - 3 * (p - 4) +: 3];
  endfunction

  function automatic logic [31:0] up_of(input ipp_src_t s);
    logic [31:0] w;
    w = '0;
    w[hb(UP_HI)] = s.hi_comm;
    w[hb(UP_LO)] = s.lo_comm;
    w[hb(UP_USB)] = s.usb;
    w[hb(UP_SD)] = s.sd_host;
    w[hb(UP_DMA1)] = s.dma1;
    w[hb(UP_UART)] = s.uart;
    w[hb(UP_CAN)] = s.can;
    w[hb(UP_I2C1)] = s.i2c1;
    w[hb(UP_I2C2)] = s.i2c2;
    w[hb(UP_SPI)] = s.spi;
    return w;
  endfunction

  function automatic logic [31:0] lo_of(input ipp_src_t s);
    logic [31:0] w;
    w = '0;
    w[hb(LO_SEC)] = s.sec_tick;
    w[hb(LO_PIT)] = s.periodic_timer_source;
    w[hb(LO_ALARM)] = s.alarm;
    w[hb(LO_BUS)] = s.bus_access;
    w[hb(LO_DMA2)] = s.dma2;
    w[hb(LO_TMR4)] = s.timer4;
    w[hb(LO_PORTS)] = s.ports;
    w[hb(LO_GPIO)] = s.gpio;
    w[hb(LO_DRAM)] = s.dram;
    w[hb(LO_LBUS)] = s.local_bus;
    w[hb(LO_TMR2)] = s.timer2;
    w[hb(LO_PMC)] = s.power_mgmt_source;
    w[hb(LO_TMR3)] = s.timer3;
    w[hb(LO_TMR1)] = s.timer1;
    w[hb(LO_DMA_ERR)] = s.dma_err;
    return w;
  endfunction
endpackage

// >>> ipp_top.sv
// Internal interrupt pending, priority and vector block with AXI4-Lite port
//
// Operation
// - Every source owns a unique seven-bit vector; codes 95 to 127 unused.
// - A source request sets its assigned pending bit.
// - Both pending registers are read-only; writes change nothing.
// - Unassigned pending bits ignore writes and read zero.
// - Pending bit positions never move with programmed priority.
// - Upper pending map: comm, USB, SD, DMA, UART, CAN, I2C, SPI.
// - Lower pending map: tick, timers, alarm, DMA, GPIO, DRAM, power.
// - Group A codes 000, 001, 110 pick comm high, comm low, USB.
// - Positions sit at bits 0-11 and 16-27; other bits read zero.
// - Priority fields may be rewritten at any time, effective at once.
// - Group B code 010 places the SD host request.
// - Group C code 010 places the first DMA request.
// - Pending sets regardless of mask; masked sources reach no core.
// - Vector register shows the best unmasked pending source code.
`timescale 1ns/100ps
module ipp_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire ipp_pkg::ipp_src_t src,
  output logic core_int_req,
  output logic [6:0] core_vector,
  output logic irq
);
  ipp_pkg::ipp_state_t s;
  ipp_pkg::ipp_state_t next_s;
  logic [31:0] act_up, act_lo, impl_up, impl_lo;
  logic [7:0] act_a, act_b, act_c, act_d;
  logic hit_a, hit_b, hit_c, hit_d, hit_lo;
  logic [2:0] code_a, code_b, code_c, code_d;
  logic [4:0] idx_lo;
  logic [6:0] best;
  logic do_wr;
  logic [2:0] ev;

  function automatic logic [31:0] wmerge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] st, input logic [31:0] keep);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b * 8 +: 8] = d[b * 8 +: 8];
      end
    end
    return r & keep;
  endfunction

  function automatic logic resv(input logic [31:0] w, input logic [7:0] ok);
    logic r;
    r = 1'b0;
    for (int p = 0; p < 8; p++) begin
      if (!ok[ipp_pkg::fld(w, p)]) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic [6:0] lo_vec(input logic [4:0] i);
    case (int'(i))
      ipp_pkg::LO_SEC: lo_vec = ipp_pkg::VEC_SEC;
      ipp_pkg::LO_PIT: lo_vec = ipp_pkg::VEC_PIT;
      ipp_pkg::LO_ALARM: lo_vec = ipp_pkg::VEC_ALARM;
      ipp_pkg::LO_BUS: lo_vec = ipp_pkg::VEC_BUS;
      ipp_pkg::LO_DMA2: lo_vec = ipp_pkg::VEC_DMA2;
      ipp_pkg::LO_TMR4: lo_vec = ipp_pkg::VEC_TMR4;
      ipp_pkg::LO_PORTS: lo_vec = ipp_pkg::VEC_PORTS;
      ipp_pkg::LO_GPIO: lo_vec = ipp_pkg::VEC_GPIO;
      ipp_pkg::LO_DRAM: lo_vec = ipp_pkg::VEC_DRAM;
      ipp_pkg::LO_LBUS: lo_vec = ipp_pkg::VEC_LBUS;
      ipp_pkg::LO_TMR2: lo_vec = ipp_pkg::VEC_TMR2;
      ipp_pkg::LO_PMC: lo_vec = ipp_pkg::VEC_PMC;
      ipp_pkg::LO_TMR3: lo_vec = ipp_pkg::VEC_TMR3;
      ipp_pkg::LO_TMR1: lo_vec = ipp_pkg::VEC_TMR1;
      ipp_pkg::LO_DMA_ERR: lo_vec = ipp_pkg::VEC_DMA_ERR;
      default: lo_vec = ipp_pkg::VEC_NONE;
    endcase
  endfunction

  // unassigned bits never hold a one
  assign impl_up = ipp_pkg::up_of('1);
  assign impl_lo = ipp_pkg::lo_of('1);
  // mask gates only what goes to the core
  assign act_up = s.pend_up & s.mask_up;
  assign act_lo = s.pend_lo & s.mask_lo;

  always_comb begin
    act_a = 8'h00;
    act_a[ipp_pkg::CODE_A_HI] = act_up[ipp_pkg::hb(ipp_pkg::UP_HI)];
    act_a[ipp_pkg::CODE_A_LO] = act_up[ipp_pkg::hb(ipp_pkg::UP_LO)];
    act_a[ipp_pkg::CODE_A_USB] = act_up[ipp_pkg::hb(ipp_pkg::UP_USB)];
    act_b = 8'h00;
    act_b[ipp_pkg::CODE_B_SD] = act_up[ipp_pkg::hb(ipp_pkg::UP_SD)];
    act_c = 8'h00;
    act_c[ipp_pkg::CODE_C_DMA] = act_up[ipp_pkg::hb(ipp_pkg::UP_DMA1)];
    act_d = 8'h00;
    act_d[ipp_pkg::CODE_D_UART] = act_up[ipp_pkg::hb(ipp_pkg::UP_UART)];
    act_d[ipp_pkg::CODE_D_CAN] = act_up[ipp_pkg::hb(ipp_pkg::UP_CAN)];
    act_d[ipp_pkg::CODE_D_I2C1] = act_up[ipp_pkg::hb(ipp_pkg::UP_I2C1)];
    act_d[ipp_pkg::CODE_D_I2C2] = act_up[ipp_pkg::hb(ipp_pkg::UP_I2C2)];
    act_d[ipp_pkg::CODE_D_SPI] = act_up[ipp_pkg::hb(ipp_pkg::UP_SPI)];
  end

  // ranking reads the live priority registers
  ipp_group_rank u_rank_a (.prio(s.prio_a), .src_act(act_a), .hit(hit_a),
    .code(code_a));
  ipp_group_rank u_rank_b (.prio(s.prio_b), .src_act(act_b), .hit(hit_b),
    .code(code_b));
  ipp_group_rank u_rank_c (.prio(s.prio_c), .src_act(act_c), .hit(hit_c),
    .code(code_c));
  ipp_group_rank u_rank_d (.prio(s.prio_d), .src_act(act_d), .hit(hit_d),
    .code(code_d));
  ipp_fixed_pick u_pick_lo (.act(act_lo), .hit(hit_lo), .idx(idx_lo));

  // groups A, B, C, D, then the lower word in bit order
  always_comb begin
    best = ipp_pkg::VEC_NONE;
    if (hit_a) begin
      case (code_a)
        ipp_pkg::CODE_A_HI: best = ipp_pkg::VEC_HI_COMM;
        ipp_pkg::CODE_A_LO: best = ipp_pkg::VEC_LO_COMM;
        default: best = ipp_pkg::VEC_USB;
      endcase
    end else if (hit_b) begin
      best = ipp_pkg::VEC_SD;
    end else if (hit_c) begin
      best = ipp_pkg::VEC_DMA1;
    end else if (hit_d) begin
      case (code_d)
        ipp_pkg::CODE_D_UART: best = ipp_pkg::VEC_UART;
        ipp_pkg::CODE_D_CAN: best = ipp_pkg::VEC_CAN;
        ipp_pkg::CODE_D_I2C1: best = ipp_pkg::VEC_I2C1;
        ipp_pkg::CODE_D_I2C2: best = ipp_pkg::VEC_I2C2;
        default: best = ipp_pkg::VEC_SPI;
      endcase
    end else if (hit_lo) begin
      best = lo_vec(idx_lo);
    end
  end

  assign awready = !s.aw_held && !s.bvalid;
  assign wready = !s.w_held && !s.bvalid;
  assign arready = !s.rvalid;
  assign do_wr = s.aw_held && s.w_held && !s.bvalid;

  always_comb begin
    logic [2:0] clr;
    logic [31:0] m;
    clr = 3'h0;
    m = '0;
    next_s = s;
    // pending is a registered copy of the request levels
    // each source lands on its fixed bit
    // bit placement ignores the priority registers
    next_s.pend_up = ipp_pkg::up_of(src);
    next_s.pend_lo = ipp_pkg::lo_of(src);
    ev = 3'h0;
    ev[0] = |(next_s.pend_up & ~s.pend_up);
    ev[1] = |(next_s.pend_lo & ~s.pend_lo);
    if (awvalid && awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_s.w_held = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (do_wr) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = ipp_pkg::RESP_OKAY;
      case (s.aw_addr)
        // reserved priority bits dropped on write
        ipp_pkg::ADDR_PRIO_A: begin
          m = wmerge(s.prio_a, s.w_data, s.w_strb, ipp_pkg::PRIO_KEEP);
          next_s.prio_a = m;
          ev[2] = resv(m, ipp_pkg::ALLOW_A);
        end
        ipp_pkg::ADDR_PRIO_B: begin
          m = wmerge(s.prio_b, s.w_data, s.w_strb, ipp_pkg::PRIO_KEEP);
          next_s.prio_b = m;
          ev[2] = resv(m, ipp_pkg::ALLOW_B);
        end
        ipp_pkg::ADDR_PRIO_C: begin
          m = wmerge(s.prio_c, s.w_data, s.w_strb, ipp_pkg::PRIO_KEEP);
          next_s.prio_c = m;
          ev[2] = resv(m, ipp_pkg::ALLOW_C);
        end
        ipp_pkg::ADDR_PRIO_D: begin
          m = wmerge(s.prio_d, s.w_data, s.w_strb, ipp_pkg::PRIO_KEEP);
          next_s.prio_d = m;
          ev[2] = resv(m, ipp_pkg::ALLOW_D);
        end
        ipp_pkg::ADDR_MASK_UP:
          next_s.mask_up = wmerge(s.mask_up, s.w_data, s.w_strb, impl_up);
        ipp_pkg::ADDR_MASK_LO:
          next_s.mask_lo = wmerge(s.mask_lo, s.w_data, s.w_strb, impl_lo);
        ipp_pkg::ADDR_EV_STAT:
          clr = s.w_strb[0] ? s.w_data[2:0] : 3'h0;
        ipp_pkg::ADDR_EV_MASK: begin
          m = wmerge({29'h0, s.ev_mask}, s.w_data, s.w_strb, 32'h0000_0007);
          next_s.ev_mask = m[2:0];
        end
        // pending and vector writes are accepted and dropped
        ipp_pkg::ADDR_PEND_UP, ipp_pkg::ADDR_PEND_LO,
        ipp_pkg::ADDR_VECTOR: next_s.bresp = ipp_pkg::RESP_OKAY;
        default: next_s.bresp = ipp_pkg::RESP_SLVERR;
      endcase
    end
    // Set beats clear so no event is lost to a racing write
    next_s.ev_stat = (s.ev_stat & ~clr) | ev;
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    // reads copy state and change nothing else
    if (arvalid && arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = ipp_pkg::RESP_OKAY;
      case (araddr)
        ipp_pkg::ADDR_VECTOR:
          next_s.rdata = {s.vector[5:0], 19'h0, s.vector};
        ipp_pkg::ADDR_PEND_UP: next_s.rdata = s.pend_up;
        ipp_pkg::ADDR_PEND_LO: next_s.rdata = s.pend_lo;
        ipp_pkg::ADDR_PRIO_A: next_s.rdata = s.prio_a;
        ipp_pkg::ADDR_PRIO_B: next_s.rdata = s.prio_b;
        ipp_pkg::ADDR_PRIO_C: next_s.rdata = s.prio_c;
        ipp_pkg::ADDR_PRIO_D: next_s.rdata = s.prio_d;
        ipp_pkg::ADDR_MASK_UP: next_s.rdata = s.mask_up;
        ipp_pkg::ADDR_MASK_LO: next_s.rdata = s.mask_lo;
        ipp_pkg::ADDR_EV_STAT: next_s.rdata = {29'h0, s.ev_stat};
        ipp_pkg::ADDR_EV_MASK: next_s.rdata = {29'h0, s.ev_mask};
        default: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = ipp_pkg::RESP_SLVERR;
        end
      endcase
    end
    // vector codes fed to the core
    next_s.vector = best;
    next_s.int_req = (best != ipp_pkg::VEC_NONE);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= ipp_pkg::ST_RST;
    end else begin
      s <= next_s;
    end
  end

  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = s.rdata;
  assign core_int_req = s.int_req;
  assign core_vector = s.vector;
  assign irq = |(s.ev_stat & s.ev_mask);

  sequence wr_to(logic [7:0] a);
    do_wr && s.aw_addr == a;
  endsequence

  sequence pend_clean;
    ((s.pend_up & ~impl_up) == 32'h0) && ((s.pend_lo & ~impl_lo) == 32'h0);
  endsequence

  a_pend_ro: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_to(ipp_pkg::ADDR_PEND_UP) |=> s.pend_up == ipp_pkg::up_of($past(src)))
    else $error("pending word took a write");

  a_pend_resv: assert property (@(posedge aclk) disable iff (!aresetn)
    pend_clean)
    else $error("unassigned pending bit set");

  a_pend_usb: assert property (@(posedge aclk) disable iff (!aresetn)
    src.usb && !s.mask_up[ipp_pkg::hb(ipp_pkg::UP_USB)]
    |=> s.pend_up[ipp_pkg::hb(ipp_pkg::UP_USB)])
    else $error("masked request did not pend");

  a_pend_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(src.sec_tick) |=> !s.pend_lo[ipp_pkg::hb(ipp_pkg::LO_SEC)])
    else $error("pending did not follow request");

  a_int_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 core_int_req == $past((|act_up) || (|act_lo)))
    else $error("core request without unmasked pending");

  a_vec_sec: assert property (@(posedge aclk) disable iff (!aresetn)
    act_up == 32'h0 && act_lo == 32'h8000_0000
    |=> core_vector == ipp_pkg::VEC_SEC)
    else $error("seconds tick vector wrong");

  a_vec_range: assert property (@(posedge aclk) disable iff (!aresetn)
    core_vector < ipp_pkg::VEC_RESV_LO)
    else $error("reserved vector code issued");

  a_prio_resv: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.prio_a & ~ipp_pkg::PRIO_KEEP) == 32'h0
    && (s.prio_b & ~ipp_pkg::PRIO_KEEP) == 32'h0)
    else $error("reserved priority bits set");

  a_prio_live: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_to(ipp_pkg::ADDR_PRIO_A) && s.w_strb == 4'hf
    |=> s.prio_a == ($past(s.w_data) & ipp_pkg::PRIO_KEEP))
    else $error("priority rewrite lost");

  a_grp_a_top: assert property (@(posedge aclk) disable iff (!aresetn)
    hit_a && ipp_pkg::fld(s.prio_a, 0) == ipp_pkg::CODE_A_USB
    && act_a[ipp_pkg::CODE_A_USB] |=> core_vector == ipp_pkg::VEC_USB)
    else $error("position zero did not win");

  a_wr_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    do_wr |=> bvalid && !awready && !wready)
    else $error("write response missing");

  a_read_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");

  a_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    ev[0] |=> s.ev_stat[0])
    else $error("event lost to clear");
endmodule
